/* src/flash_seq_pkg.sv */
// Shared constants for the flash sequencer end-address and status block.
package flash_seq_pkg;

    // Bus widths.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;

    // Register byte addresses on the peripheral bus.
    localparam logic [31:0] ADDR_END_ADDRESS = 32'h407fe034;
    localparam logic [31:0] ADDR_STATUS      = 32'h407fe080;
    // Byte address of the command-issuing area that program data is written to.
    localparam logic [31:0] ADDR_CMD_AREA    = 32'h407e0000;

    // End-address register layout.
    localparam logic [31:0] END_RESET      = 32'h00000000;
    localparam logic [31:0] END_RO_MASK    = 32'h00000003;
    localparam logic [31:0] END_PROC_MASK  = 32'h0007fffc;

    // Status register bit positions.
    localparam int BIT_PROTECT   = 6;
    localparam int BIT_PRG_SPD   = 8;
    localparam int BIT_ERS_SPD   = 9;
    localparam int BIT_BUF_FULL  = 10;
    localparam int BIT_SUSP_OK   = 11;
    localparam int BIT_PROG_ERR  = 12;
    localparam int BIT_ERASE_ERR = 13;
    localparam int BIT_ILLEGAL   = 14;
    localparam int BIT_IDLE      = 15;
    localparam int BIT_MISC      = 20;
    localparam int BIT_SEC       = 21;
    localparam int BIT_MODE      = 22;
    localparam int BIT_BADCMD    = 23;

    // Reserved status bits, which always read as zero.
    localparam logic [31:0] STATUS_RESV_MASK = 32'hff0f00bf;

    // Index of each error flag in the sticky error vector.
    localparam int ERR_N       = 8;
    localparam int ERR_ILLEGAL = 0;
    localparam int ERR_ERASE   = 1;
    localparam int ERR_PROG    = 2;
    localparam int ERR_PROTECT = 3;
    localparam int ERR_MISC    = 4;
    localparam int ERR_SEC     = 5;
    localparam int ERR_MODE    = 6;
    localparam int ERR_BADCMD  = 7;

    // Bus encodings and the reset value of the idle flag.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'h0;
    localparam logic       IDLE_RESET = 1'h1;

endpackage

/* src/sticky_flag.sv */
// One hardware-set status flag whose set beats its clear.
`timescale 1ns/100ps
module sticky_flag (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic set,
    input  wire logic clr,
    output logic      q_ff
);

    logic nxt_q; // Next flag value.

    // A set in the same cycle as a clear keeps the flag high.
    always_comb begin
        nxt_q = q_ff;
        if (set) begin
            nxt_q = 1'b1;
        end else if (clr) begin
            nxt_q = 1'b0;
        end
    end

    // Register the flag; it is low after reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule

/* src/ahb_addr_phase.sv */
// Captures an accepted AHB-Lite address phase for use in its data phase.
`timescale 1ns/100ps
module ahb_addr_phase
    import flash_seq_pkg::*;
(
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    input  wire logic                             hsel,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [flash_seq_pkg::ADDR_W-1:0] haddr,
    input  wire logic                             hready,
    output logic                                  take,
    output logic                                  dp_valid_ff,
    output logic                                  dp_write_ff,
    output logic [flash_seq_pkg::ADDR_W-1:0]      dp_addr_ff
);

    logic              nxt_dp_valid; // Next data-phase valid.
    logic              nxt_dp_write; // Next data-phase direction.
    logic [ADDR_W-1:0] nxt_dp_addr;  // Next data-phase address.

    // An address phase is taken when selected, active and the bus is ready.
    always_comb begin
        take         = hsel && htrans[1] && hready;
        nxt_dp_valid = dp_valid_ff;
        nxt_dp_write = dp_write_ff;
        nxt_dp_addr  = dp_addr_ff;
        if (hready) begin
            nxt_dp_valid = take;
            nxt_dp_write = take && hwrite && (hsize == HSIZE_WORD);
            nxt_dp_addr  = haddr;
        end
    end

    // Hold the captured phase until the bus is ready again.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= '0;
        end else begin
            dp_valid_ff <= nxt_dp_valid;
            dp_write_ff <= nxt_dp_write;
            dp_addr_ff  <= nxt_dp_addr;
        end
    end

endmodule

/* src/flash_seq_end_addr_and_status.sv */
// End-address register, direction check and status register of the flash sequencer.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
module flash_seq_end_addr_and_status
    import flash_seq_pkg::*;
(
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    // AHB-Lite slave port.
    input  wire logic                             hsel,
    input  wire logic [flash_seq_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [flash_seq_pkg::DATA_W-1:0] hwdata,
    input  wire logic                             hready,
    output logic                                  hreadyout,
    output logic      [flash_seq_pkg::DATA_W-1:0] hrdata,
    output logic                                  hresp,
    // Links to the rest of the sequencer.
    input  wire logic [flash_seq_pkg::DATA_W-1:0] command_start_address,
    input  wire logic                             blank_check_direction,
    input  wire logic                             blank_check_start,
    input  wire logic                             settings_init_request,
    input  wire logic                             cmd_accepted,
    input  wire logic                             cmd_done,
    input  wire logic                             status_clear_start,
    input  wire logic                             status_clear_done,
    input  wire logic                             forced_stop_start,
    input  wire logic                             forced_stop_done,
    input  wire logic                             prog_suspend_start,
    input  wire logic                             erase_suspend_start,
    input  wire logic                             resume_accepted,
    input  wire logic                             suspend_acceptable,
    input  wire logic                             write_buffer_full,
    input  wire logic                             illegal_access_event,
    input  wire logic                             erase_error_event,
    input  wire logic                             program_error_event,
    input  wire logic                             write_protect_event,
    input  wire logic                             miscellaneous_event,
    input  wire logic                             security_event,
    input  wire logic                             mode_entry_event,
    input  wire logic                             bad_command_event,
    output logic      [flash_seq_pkg::DATA_W-1:0] proc_end_address,
    output logic                                  command_locked,
    output logic                                  sequencer_idle_flag,
    output logic                                  cmd_wr_valid,
    output logic      [flash_seq_pkg::DATA_W-1:0] cmd_wr_data
);

    // Captured address phase.
    logic              take;         // Address phase accepted this cycle.
    logic              dp_valid_ff;  // A data phase is in progress.
    logic              dp_write_ff;  // The data phase is a word write.
    logic [ADDR_W-1:0] dp_addr_ff;   // Address of the data phase.

    // Bus answer state.
    logic              hreadyout_ff;     // Registered ready.
    logic              nxt_hreadyout;    // Next ready.
    logic [DATA_W-1:0] hrdata_ff;        // Registered read data.
    logic [DATA_W-1:0] nxt_hrdata;       // Next read data.
    logic              cmd_wr_valid_ff;  // Command-area write pulse.
    logic              nxt_cmd_wr_valid; // Next command-area write pulse.
    logic [DATA_W-1:0] cmd_wr_data_ff;   // Command-area write data.
    logic [DATA_W-1:0] nxt_cmd_wr_data;  // Next command-area write data.
    logic              wr_done;          // A write data phase completes.

    // Sequencer state.
    logic [DATA_W-1:0] end_addr_ff;      // Blank check end address.
    logic [DATA_W-1:0] nxt_end_addr;     // Next end address.
    logic [DATA_W-1:0] proc_end_ff;      // End address as used by processing.
    logic [DATA_W-1:0] nxt_proc_end;     // Next processing end address.
    logic              idle_ff;          // Sequencer idle flag.
    logic              nxt_idle;         // Next idle flag.
    logic              locked_ff;        // Command-locked state.
    logic              nxt_locked;       // Next command-locked state.
    logic              susp_ok_ff;       // Suspend command acceptable.
    logic              buf_full_ff;      // Write buffer full.
    logic              nxt_susp_ok;      // Next suspend acceptable.
    logic              nxt_buf_full;     // Next write buffer full.
    logic              prg_spd_ff;       // Program suspending or suspended.
    logic              ers_spd_ff;       // Erase suspending or suspended.
    logic              nxt_prg_spd;      // Next program suspend state.
    logic              nxt_ers_spd;      // Next erase suspend state.
    logic              dir_bad;          // Start and end disagree with direction.
    logic [ERR_N-1:0]  err_set;          // Set strobes for the error flags.
    logic [ERR_N-1:0]  err_clr;          // Clear strobes for the error flags.
    logic [ERR_N-1:0]  err_q;            // Error flag values.
    logic [DATA_W-1:0] status_word;      // Assembled status register.

    // Address-phase capture for the bus.
    ahb_addr_phase u_addr_phase (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .haddr       (haddr),
        .hready      (hready),
        .take        (take),
        .dp_valid_ff (dp_valid_ff),
        .dp_write_ff (dp_write_ff),
        .dp_addr_ff  (dp_addr_ff)
    );

    // Ordering check for a blank check against the chosen direction.
    always_comb begin
        if (blank_check_direction) begin
            dir_bad = !(command_start_address > end_addr_ff);
        end else begin
            dir_bad = !(command_start_address < end_addr_ff);
        end
    end

    // Set and clear strobes of the eight sticky error flags.
    always_comb begin
        err_set              = '0;
        err_set[ERR_ILLEGAL] = illegal_access_event || (blank_check_start && dir_bad);
        err_set[ERR_ERASE]   = erase_error_event;
        err_set[ERR_PROG]    = program_error_event;
        err_set[ERR_PROTECT] = write_protect_event;
        err_set[ERR_MISC]    = miscellaneous_event;
        err_set[ERR_SEC]     = security_event;
        err_set[ERR_MODE]    = mode_entry_event;
        err_set[ERR_BADCMD]  = bad_command_event;
        err_clr              = '0;
        err_clr[ERR_ILLEGAL] = status_clear_start || forced_stop_start;
        err_clr[ERR_ERASE]   = status_clear_start || forced_stop_start;
        err_clr[ERR_PROG]    = status_clear_start || forced_stop_start;
        err_clr[ERR_PROTECT] = forced_stop_start;
        err_clr[ERR_MISC]    = status_clear_done || forced_stop_done;
        err_clr[ERR_SEC]     = status_clear_done || forced_stop_done;
        err_clr[ERR_MODE]    = status_clear_done || forced_stop_done;
        err_clr[ERR_BADCMD]  = status_clear_done || forced_stop_done;
    end

    // One sticky flag per error; only sequencer strobes reach them.
    for (genvar gi = 0; gi < ERR_N; gi++) begin : g_err
        sticky_flag u_flag (
            .hclk    (hclk),
            .hresetn (hresetn),
            .set     (err_set[gi]),
            .clr     (err_clr[gi]),
            .q_ff    (err_q[gi])
        );
    end

    // Status word built from flops; reserved bits stay zero.
    always_comb begin
        status_word                = '0;
        status_word[BIT_IDLE]      = idle_ff;
        status_word[BIT_ILLEGAL]   = err_q[ERR_ILLEGAL];
        status_word[BIT_ERASE_ERR] = err_q[ERR_ERASE];
        status_word[BIT_PROG_ERR]  = err_q[ERR_PROG];
        status_word[BIT_SUSP_OK]   = susp_ok_ff;
        status_word[BIT_BUF_FULL]  = buf_full_ff;
        status_word[BIT_ERS_SPD]   = ers_spd_ff;
        status_word[BIT_PRG_SPD]   = prg_spd_ff;
        status_word[BIT_PROTECT]   = err_q[ERR_PROTECT];
        status_word[BIT_MISC]      = err_q[ERR_MISC];
        status_word[BIT_SEC]       = err_q[ERR_SEC];
        status_word[BIT_MODE]      = err_q[ERR_MODE];
        status_word[BIT_BADCMD]    = err_q[ERR_BADCMD];
    end

    // Bus answer: read data, wait states and command-area write pulses.
    always_comb begin
        wr_done          = dp_valid_ff && dp_write_ff && hreadyout_ff;
        nxt_hrdata       = hrdata_ff;
        nxt_hreadyout    = 1'b1;
        nxt_cmd_wr_valid = 1'b0;
        nxt_cmd_wr_data  = cmd_wr_data_ff;
        // Read data is fetched in the address phase so it stands in the data phase.
        if (take) begin
            if (haddr == ADDR_END_ADDRESS) begin
                nxt_hrdata = end_addr_ff;
            end else if (haddr == ADDR_STATUS) begin
                nxt_hrdata = status_word;
            end else begin
                nxt_hrdata = '0;
            end
        end
        // A program data write into a full buffer waits until space frees up.
        if (take && hwrite && (haddr == ADDR_CMD_AREA)) begin
            nxt_hreadyout = !write_buffer_full;
        end else if (dp_valid_ff && dp_write_ff && !hreadyout_ff) begin
            nxt_hreadyout = !write_buffer_full;
        end
        // The write is handed to the sequencer once its data phase completes.
        if (wr_done && (dp_addr_ff == ADDR_CMD_AREA)) begin
            nxt_cmd_wr_valid = 1'b1;
            nxt_cmd_wr_data  = hwdata;
        end
    end

    // Register the bus answer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff    <= 1'b1;
            hrdata_ff       <= '0;
            cmd_wr_valid_ff <= 1'b0;
            cmd_wr_data_ff  <= '0;
        end else begin
            hreadyout_ff    <= nxt_hreadyout;
            hrdata_ff       <= nxt_hrdata;
            cmd_wr_valid_ff <= nxt_cmd_wr_valid;
            cmd_wr_data_ff  <= nxt_cmd_wr_data;
        end
    end

    // Next state of the end address, idle flag, lock and suspend flags.
    always_comb begin
        nxt_end_addr = end_addr_ff;
        // Software may only load the end address while the sequencer is idle.
        if (settings_init_request) begin
            nxt_end_addr = END_RESET;
        end else if (wr_done && (dp_addr_ff == ADDR_END_ADDRESS) && idle_ff) begin
            nxt_end_addr = (hwdata & ~END_RO_MASK) | (end_addr_ff & END_RO_MASK);
        end
        // Processing ignores the upper bits and the two low bits.
        nxt_proc_end = nxt_end_addr & END_PROC_MASK;
        // Acceptance of a command takes priority over a completion.
        nxt_idle = idle_ff;
        if (cmd_accepted) begin
            nxt_idle = 1'b0;
        end else if (cmd_done || forced_stop_done) begin
            nxt_idle = 1'b1;
        end
        // Any raised error flag holds the sequencer locked.
        nxt_locked   = |err_q;
        nxt_susp_ok  = suspend_acceptable && !locked_ff;
        nxt_buf_full = write_buffer_full;
        // Suspend flags set on suspend start, clear on resume or forced stop.
        nxt_prg_spd = prg_spd_ff;
        if (prog_suspend_start) begin
            nxt_prg_spd = 1'b1;
        end else if (resume_accepted || forced_stop_start) begin
            nxt_prg_spd = 1'b0;
        end
        nxt_ers_spd = ers_spd_ff;
        if (erase_suspend_start) begin
            nxt_ers_spd = 1'b1;
        end else if (resume_accepted || forced_stop_start) begin
            nxt_ers_spd = 1'b0;
        end
    end

    // Register the sequencer state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            end_addr_ff <= END_RESET;
            proc_end_ff <= END_RESET;
            idle_ff     <= IDLE_RESET;
            locked_ff   <= 1'b0;
            susp_ok_ff  <= 1'b0;
            buf_full_ff <= 1'b0;
            prg_spd_ff  <= 1'b0;
            ers_spd_ff  <= 1'b0;
        end else begin
            end_addr_ff <= nxt_end_addr;
            proc_end_ff <= nxt_proc_end;
            idle_ff     <= nxt_idle;
            locked_ff   <= nxt_locked;
            susp_ok_ff  <= nxt_susp_ok;
            buf_full_ff <= nxt_buf_full;
            prg_spd_ff  <= nxt_prg_spd;
            ers_spd_ff  <= nxt_ers_spd;
        end
    end

    // Outputs come straight from flops; the response is always OKAY.
    assign hreadyout           = hreadyout_ff;
    assign hrdata              = hrdata_ff;
    assign hresp               = HRESP_OKAY;
    assign proc_end_address    = proc_end_ff;
    assign command_locked      = locked_ff;
    assign sequencer_idle_flag = idle_ff;
    assign cmd_wr_valid        = cmd_wr_valid_ff;
    assign cmd_wr_data         = cmd_wr_data_ff;

    // A write while busy leaves the end address unchanged.
    a_end_busy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_done && dp_addr_ff == ADDR_END_ADDRESS && !idle_ff && !settings_init_request)
        |=> $stable(end_addr_ff))
        else $error("End address changed while sequencer busy.");

    // The two low end-address bits never leave zero.
    a_end_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (end_addr_ff & END_RO_MASK) == '0)
        else $error("End address low bits are not zero.");

    // An idle write lands in the end address on the next edge.
    a_end_write_load: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_done && dp_addr_ff == ADDR_END_ADDRESS && idle_ff && !settings_init_request)
        |=> end_addr_ff == ($past(hwdata) & ~END_RO_MASK))
        else $error("Idle end-address write not stored.");

    // A bad ordering raises the lock two edges later and holds it.
    a_dir_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        (blank_check_start && dir_bad && !status_clear_start && !forced_stop_start)
        |=> err_q[ERR_ILLEGAL] ##1 command_locked)
        else $error("Direction mismatch did not lock the sequencer.");

    // Initialisation zeroes the end address and its processed copy.
    a_init_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        settings_init_request |=> (end_addr_ff == '0 && proc_end_address == '0))
        else $error("Settings init did not clear the end address.");

    // The processed end address only carries bits 18 to 2.
    a_proc_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        proc_end_address == (end_addr_ff & END_PROC_MASK))
        else $error("Processed end address mask wrong.");

    // Accepting a command drops the idle flag next edge.
    a_idle_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_accepted |=> !sequencer_idle_flag && !status_word[BIT_IDLE])
        else $error("Idle flag did not clear on command acceptance.");

    // A program data write into a full buffer is held off.
    a_full_stall: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && haddr == ADDR_CMD_AREA && write_buffer_full) |=> !hreadyout)
        else $error("Write into full buffer was not stalled.");

    // Reserved status bits read as zero.
    a_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (status_word & STATUS_RESV_MASK) == '0)
        else $error("Reserved status bit is set.");

    // A programming error shows in bit 12 until cleared.
    a_prog_err_seen: assert property (@(posedge hclk) disable iff (!hresetn)
        program_error_event |=> status_word[BIT_PROG_ERR] ##1 command_locked)
        else $error("Programming error not reported.");

endmodule

/* verif/ahb_host.sv */
// Host model that issues single-word AHB-Lite transfers.
`timescale 1ns/100ps
module ahb_host
    import flash_seq_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // Idle bus at time zero; write data goes out as given, reserved bits included.
    initial {hsel, htrans, hwrite, hsize, haddr, hwdata} = '0;
    // One transfer: address phase held until ready, then data phase held until ready.
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge hclk);
        {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, HSIZE_WORD, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the end-address and status block.
`timescale 1ns/100ps
module testbench;
    import flash_seq_pkg::*;
    logic        hclk = 0, hresetn = 0, wbf = 0, sok = 0, dir = 0;
    logic [18:0] ev = '0;
    logic [31:0] start = '0, q, haddr, hwdata, hrdata, ped, cwd;
    logic        hsel, hwrite, hready, lock, idle, cwv, resp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          errors = 0, check_count = 0, stall_n = 0;
    int          evt[10] = '{9, 10, 11, 12, 13, 14, 15, 16, 6, 7};
    int          bpos[10] = '{14, 13, 12, 6, 20, 21, 22, 23, 8, 9};
    always #12.5 hclk = ~hclk;
    // Counts wait states inserted by the block.
    always @(posedge hclk)
        if (hready === 1'b0) stall_n <= stall_n + 1;
    ahb_host ahb_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    flash_seq_end_addr_and_status flash_seq_end_addr_and_status_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(resp), .command_start_address(start),
        .blank_check_direction(dir), .blank_check_start(ev[17]),
        .settings_init_request(ev[18]), .cmd_accepted(ev[0]), .cmd_done(ev[1]),
        .status_clear_start(ev[2]), .status_clear_done(ev[3]), .forced_stop_start(ev[4]),
        .forced_stop_done(ev[5]), .prog_suspend_start(ev[6]), .erase_suspend_start(ev[7]),
        .resume_accepted(ev[8]), .suspend_acceptable(sok), .write_buffer_full(wbf),
        .illegal_access_event(ev[9]), .erase_error_event(ev[10]),
        .program_error_event(ev[11]), .write_protect_event(ev[12]),
        .miscellaneous_event(ev[13]), .security_event(ev[14]), .mode_entry_event(ev[15]),
        .bad_command_event(ev[16]), .proc_end_address(ped), .command_locked(lock),
        .sequencer_idle_flag(idle), .cmd_wr_valid(cwv), .cmd_wr_data(cwd));
    task automatic check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        ahb_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, e);
        ahb_host_i.xfer(1'b0, a, 32'h0, q);
        check(q, e, "read data");
    endtask
    // One-cycle strobe on a sequencer event line.
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge hclk);
        ev[i] <= 1'b0;
    endtask
    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge hclk);
        errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_STATUS, 32'h00008000);
        rd(ADDR_END_ADDRESS, 32'h00000000);
        wr(ADDR_END_ADDRESS, 32'hffffffff);
        rd(ADDR_END_ADDRESS, 32'hfffffffc);
        check(ped, 32'h0007fffc, "processing end");
        wr(ADDR_STATUS, 32'hffffffff);
        rd(ADDR_STATUS, 32'h00008000);
        // Each flag sets on its event; a status clear, resume or forced stop clears it.
        for (int k = 0; k < 10; k++) begin
            pulse(evt[k]);
            rd(ADDR_STATUS, 32'h00008000 | (32'h1 << bpos[k]));
            check({31'h0, lock}, {31'h0, k < 8}, "locked");
            if (k == 8) begin
                pulse(8);
            end else if (!k[0]) begin
                pulse(2);
                pulse(3);
            end else begin
                pulse(4);
                pulse(5);
            end
            rd(ADDR_STATUS, 32'h00008000);
        end
        sok <= 1'b1;
        wbf <= 1'b1;
        rd(ADDR_STATUS, 32'h00008c00);
        fork
            begin
                repeat (6) @(posedge hclk);
                wbf <= 1'b0;
            end
        join_none
        wr(ADDR_CMD_AREA, 32'h0000005a);
        @(posedge hclk);
        check({31'h0, cwv}, 32'h1, "command strobe");
        @(posedge hclk);
        check({31'h0, cwv}, 32'h0, "command strobe end");
        check({31'h0, resp}, {31'h0, HRESP_OKAY}, "response");
        check(32'(stall_n > 0), 32'h1, "wait states");
        check(cwd, 32'h0000005a, "command data");
        wr(ADDR_END_ADDRESS, 32'h00000100);
        pulse(0);
        rd(ADDR_STATUS, 32'h00000800);
        wr(ADDR_END_ADDRESS, 32'h00000300);
        rd(ADDR_END_ADDRESS, 32'h00000100);
        pulse(1);
        rd(ADDR_STATUS, 32'h00008800);
        // Both directions, with start on either side of the end address.
        for (int k = 0; k < 4; k++) begin
            dir <= k[1];
            start <= k[0] ? 32'h00000200 : 32'h00000000;
            pulse(17);
            // Let the lock reach the suspend-ready bit before the status is read.
            repeat (2) @(posedge hclk);
            rd(ADDR_STATUS, (k[0] ^ k[1]) ? 32'h0000c000 : 32'h00008800);
            check({31'h0, lock}, {31'h0, k[0] ^ k[1]}, "locked");
            pulse(4);
            pulse(5);
        end
        pulse(18);
        rd(ADDR_END_ADDRESS, 32'h00000000);
        // A reset in mid-run clears a loaded end address as well.
        wr(ADDR_END_ADDRESS, 32'h00000040);
        rd(ADDR_END_ADDRESS, 32'h00000040);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_END_ADDRESS, 32'h00000000);
        conclude();
    end
endmodule
